/* src/mbes_pkg.sv */
// shared constants and carriers for the broadcast and error statistics
// assumes one clock domain and event strobes already synchronous to it
package mbes_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_BCAST_RX_OCTETS = 8'hb0;
    localparam logic [7:0] ADDR_BCAST_TX_OCTETS = 8'hd8;
    localparam logic [7:0] ADDR_CARRIER_LOSS    = 8'hf8;
    localparam logic [7:0] ADDR_COLL_ABORT      = 8'hfc;

    // ****************************************************************
    // reset values, limits and thresholds
    // ****************************************************************
    localparam logic [31:0] OCTET_RESET     = 32'h00000000;
    localparam logic [15:0] SHORT_RESET     = 16'h0000;
    localparam logic [31:0] OCTET_WRAP_MAX  = 32'h0fffffff;
    localparam logic [15:0] CARRIER_WRAP    = 16'hffff;
    localparam logic [15:0] COLL_WRAP       = 16'h0fff;
    localparam logic [31:0] OCTET_THRESHOLD = 32'hc0000000;
    localparam logic [15:0] SHORT_THRESHOLD = 16'hc000;
    localparam logic [15:0] VLAN_TAG_OCTETS = 16'h0004;
    localparam logic [31:0] READ_UNMAPPED   = 32'h00000000;

    // ****************************************************************
    // per counter inhibit bit positions
    // ****************************************************************
    localparam int INH_BCAST_RX   = 0;
    localparam int INH_BCAST_TX   = 1;
    localparam int INH_CARRIER    = 2;
    localparam int INH_COLL_ABORT = 3;
    localparam int NUM_COUNTERS   = 4;

    // ****************************************************************
    // event carriers from the mac paths
    // ****************************************************************
    typedef struct packed {
        logic        done;          // one-cycle end of received frame
        logic        bcast;         // destination was all ones
        logic        too_long;      // frame too long
        logic        fcs_err;       // fcs check failed
        logic        length_err;    // length field mismatch
        logic        align_err;     // alignment error
        logic        overrun;       // lost to internal overrun
        logic        vlan_stripped; // tag removed before counting point
        logic [15:0] octets;        // data and padding octets
    } mbes_rx_evt_s;

    typedef struct packed {
        logic        done_ok;       // one-cycle end of good transmission
        logic        bcast;         // destination was all ones
        logic        vlan_inserted; // tag added after counting point
        logic [15:0] octets;        // data and padding octets
        logic        start;         // one-cycle start of a frame
        logic        sfd_sent;      // one-cycle, preamble and sfd out
        logic        end_frame;     // one-cycle, frame over (any outcome)
        logic        collision;     // collision level
        logic        carrier;       // carrier sense level
        logic        abort_excess;  // one-cycle, dropped on excess colls
    } mbes_tx_evt_s;

endpackage

/* src/mbes_stats.sv */
// four mac statistics counters: broadcast octets rx/tx, carrier loss,
// excess-collision aborts, with threshold event and a simple reg port
// assumes all inputs synchronous to core_clk and one-cycle event strobes
//
// How it works
// - add good broadcast rx octets to counter
// - skip errored or overrun rx frames
// - rx octet counter wraps past its maximum
// - add good broadcast tx octets, wrapping
// - vlan tag octets always counted
// - octet counters reaching threshold raise event
// - carrier counter reaching threshold raises event; default abort wrap sits below it
// - count only when enabled and not inhibited
// - count carrier drops in collision-free frames
// - ignore carrier until sfd sent
// - carrier count 16 bits, wraps after ffff
// - count frames aborted on excess collisions
// - abort counter wraps past printed limit
// - octet counters reset zero, word access
`timescale 1ns/1ps

module mbes_stats #(
    parameter logic [31:0] OCTET_MAX = mbes_pkg::OCTET_WRAP_MAX,
    parameter logic [15:0] CARR_MAX  = mbes_pkg::CARRIER_WRAP,
    parameter logic [15:0] COLL_MAX  = mbes_pkg::COLL_WRAP
) (
    input  wire logic                   core_clk,           // 40 mhz clock
    input  wire logic                   sys_rst,            // sync reset
    input  wire logic [7:0]             reg_addr,           // byte offset
    input  wire logic                   reg_wr,             // write strobe
    input  wire logic                   reg_rd,             // read strobe
    input  wire logic [31:0]            reg_wdata,          // write data
    output logic      [31:0]            reg_rdata,          // read data
    output logic                        reg_rvalid,         // read done
    input  wire logic                   global_counting_on, // stats enable
    input  wire logic [3:0]             per_counter_inhibit,// mask bits
    input  wire mbes_pkg::mbes_rx_evt_s rx_evt,             // rx events
    input  wire mbes_pkg::mbes_tx_evt_s tx_evt,             // tx events
    output logic                        counter_threshold_event // pulse
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] wrap_add(input logic [31:0] old_val,
                                             input logic [31:0] add_val,
                                             input logic [31:0] max_val);
        logic [32:0] sum;
        logic [32:0] over;
        // one fold is enough: an add never spans a whole wrap
        sum  = {1'b0, old_val} + {1'b0, add_val};
        over = sum - {1'b0, max_val} - 33'h000000001;
        if (sum > {1'b0, max_val}) begin
            return over[31:0];
        end
        return sum[31:0];
    endfunction

    // true when an increment climbs from below the threshold to it
    function automatic logic crossed(input logic [31:0] old_val,
                                     input logic [31:0] new_val,
                                     input logic [31:0] thr);
        return (old_val < thr) && (new_val >= thr);
    endfunction

    function automatic logic counting(input logic inhibit);
        return global_counting_on && !inhibit;
    endfunction

    function automatic logic [31:0] widen(input logic [15:0] v);
        return {16'h0000, v};
    endfunction

    function automatic logic wr_to(input logic [7:0] offset);
        return reg_wr && (reg_addr == offset);
    endfunction

    // ****************************************************************
    // counters and next values
    // ****************************************************************
    // default wrap limits sit below the octet threshold;
    // raise OCTET_MAX where that event must be reachable
    logic [31:0] broadcast_rx_octet_count;
    logic [31:0] broadcast_tx_octet_count;
    logic [15:0] carrier_loss_count;
    logic [15:0] collision_abort_count;

    logic [31:0] next_rx_octets;
    logic [31:0] next_tx_octets;
    logic [31:0] next_carrier;
    logic [31:0] next_coll;
    logic [31:0] rx_add;
    logic [31:0] tx_add;

    logic        rx_inc;
    logic        tx_inc;
    logic        carrier_inc;
    logic        coll_inc;

    logic        wr_rx;
    logic        wr_tx;
    logic        wr_carrier;
    logic        wr_coll;

    logic        rx_clean;
    logic        carrier_fell;
    logic [3:0]  gate_open;
    logic        rx_hit;
    logic        tx_hit;
    logic        carrier_hit;
    logic        coll_hit;

    // ****************************************************************
    // carrier watch during transmit
    // ****************************************************************
    logic        past_sfd;
    logic        frame_collided;
    logic        carrier_q;

    // data phase only
    // start or end clears it, no stale sfd
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            past_sfd <= 1'b0;
        end else if (tx_evt.start || tx_evt.end_frame) begin
            past_sfd <= 1'b0;
        end else if (tx_evt.sfd_sent) begin
            past_sfd <= 1'b1;
        end
    end

    // collided frames excluded
    // a collision on the start cycle counts too
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            frame_collided <= 1'b0;
        end else if (tx_evt.start) begin
            frame_collided <= tx_evt.collision;
        end else if (tx_evt.collision) begin
            frame_collided <= 1'b1;
        end
    end

    // last cycle's carrier, for the falling edge
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            carrier_q <= 1'b0;
        end else begin
            carrier_q <= tx_evt.carrier;
        end
    end

    // ****************************************************************
    // increment conditions
    // ****************************************************************
    // enable and inhibit gate
    // one gate per counter, in inhibit bit order
    always_comb begin
        for (int i = 0; i < mbes_pkg::NUM_COUNTERS; i++) begin
            gate_open[i] = counting(per_counter_inhibit[i]);
        end
    end

    always_comb begin
        rx_clean = !rx_evt.too_long && !rx_evt.fcs_err
                   && !rx_evt.length_err && !rx_evt.align_err
                   && !rx_evt.overrun;
        rx_inc = rx_evt.done && rx_evt.bcast && rx_clean
                 && gate_open[mbes_pkg::INH_BCAST_RX];
        tx_inc = tx_evt.done_ok && tx_evt.bcast
                 && gate_open[mbes_pkg::INH_BCAST_TX];
        carrier_fell = carrier_q && !tx_evt.carrier;
        carrier_inc = carrier_fell && past_sfd
                      && !frame_collided && !tx_evt.collision
                      && gate_open[mbes_pkg::INH_CARRIER];
        coll_inc = tx_evt.abort_excess
                   && gate_open[mbes_pkg::INH_COLL_ABORT];
    end

    always_comb begin
        // tag octets counted
        // tags are added back so tagged frames count whole
        rx_add = {16'h0000, rx_evt.octets};
        if (rx_evt.vlan_stripped) begin
            rx_add = rx_add + {16'h0000, mbes_pkg::VLAN_TAG_OCTETS};
        end
        tx_add = {16'h0000, tx_evt.octets};
        if (tx_evt.vlan_inserted) begin
            tx_add = tx_add + {16'h0000, mbes_pkg::VLAN_TAG_OCTETS};
        end
    end

    always_comb begin
        next_rx_octets = wrap_add(broadcast_rx_octet_count, rx_add,
                                  OCTET_MAX);
        next_tx_octets = wrap_add(broadcast_tx_octet_count, tx_add,
                                  OCTET_MAX);
        next_carrier = wrap_add({16'h0000, carrier_loss_count},
                                32'h00000001, {16'h0000, CARR_MAX});
        next_coll = wrap_add({16'h0000, collision_abort_count},
                             32'h00000001, {16'h0000, COLL_MAX});
    end

    // ****************************************************************
    // write decode
    // ****************************************************************
    // unmapped writes match nothing and drop
    always_comb begin
        wr_rx      = wr_to(mbes_pkg::ADDR_BCAST_RX_OCTETS);
        wr_tx      = wr_to(mbes_pkg::ADDR_BCAST_TX_OCTETS);
        wr_carrier = wr_to(mbes_pkg::ADDR_CARRIER_LOSS);
        wr_coll    = wr_to(mbes_pkg::ADDR_COLL_ABORT);
    end

    // ****************************************************************
    // counter registers
    // ****************************************************************
    // reset to zero
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            broadcast_rx_octet_count <= mbes_pkg::OCTET_RESET;
        end else if (wr_rx) begin
            broadcast_rx_octet_count <= reg_wdata;
        end else if (rx_inc) begin
            broadcast_rx_octet_count <= next_rx_octets;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            broadcast_tx_octet_count <= mbes_pkg::OCTET_RESET;
        end else if (wr_tx) begin
            broadcast_tx_octet_count <= reg_wdata;
        end else if (tx_inc) begin
            broadcast_tx_octet_count <= next_tx_octets;
        end
    end

    // narrow registers take the low half; upper write bits dropped
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            carrier_loss_count <= mbes_pkg::SHORT_RESET;
        end else if (wr_carrier) begin
            carrier_loss_count <= reg_wdata[15:0];
        end else if (carrier_inc) begin
            carrier_loss_count <= next_carrier[15:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            collision_abort_count <= mbes_pkg::SHORT_RESET;
        end else if (wr_coll) begin
            collision_abort_count <= reg_wdata[15:0];
        end else if (coll_inc) begin
            collision_abort_count <= next_coll[15:0];
        end
    end

    // ****************************************************************
    // threshold crossings
    // ****************************************************************
    always_comb begin
        rx_hit = rx_inc && !wr_rx
                 && crossed(broadcast_rx_octet_count, next_rx_octets,
                            mbes_pkg::OCTET_THRESHOLD);
        tx_hit = tx_inc && !wr_tx
                 && crossed(broadcast_tx_octet_count, next_tx_octets,
                            mbes_pkg::OCTET_THRESHOLD);
        carrier_hit = carrier_inc && !wr_carrier
                      && crossed(widen(carrier_loss_count), next_carrier,
                                 widen(mbes_pkg::SHORT_THRESHOLD));
        coll_hit = coll_inc && !wr_coll
                   && crossed(widen(collision_abort_count), next_coll,
                              widen(mbes_pkg::SHORT_THRESHOLD));
    end

    // ****************************************************************
    // threshold event
    // ****************************************************************
    // only hardware increments fire it, a software load never does
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            counter_threshold_event <= 1'b0;
        end else begin
            counter_threshold_event <= rx_hit || tx_hit
                                       || carrier_hit || coll_hit;
        end
    end

    // ****************************************************************
    // read port
    // ****************************************************************
    // whole word reads
    // data stands until the next read
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rdata <= mbes_pkg::READ_UNMAPPED;
        end else if (reg_rd) begin
            case (reg_addr)
                mbes_pkg::ADDR_BCAST_RX_OCTETS: begin
                    reg_rdata <= broadcast_rx_octet_count;
                end
                mbes_pkg::ADDR_BCAST_TX_OCTETS: begin
                    reg_rdata <= broadcast_tx_octet_count;
                end
                mbes_pkg::ADDR_CARRIER_LOSS: begin
                    reg_rdata <= {16'h0000, carrier_loss_count};
                end
                mbes_pkg::ADDR_COLL_ABORT: begin
                    reg_rdata <= {16'h0000, collision_abort_count};
                end
                default: begin
                    reg_rdata <= mbes_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            reg_rvalid <= 1'b0;
        end else begin
            // one-cycle answer to every read strobe
            reg_rvalid <= reg_rd;
        end
    end

endmodule

/* tb/mbes_mac_model.sv */
// behavioural mac event source: rx and tx frame outcomes
// assumes the bench calls its tasks just after a core_clk edge
`timescale 1ns/1ps

module mbes_mac_model (
    input  wire logic              core_clk, // clock
    output mbes_pkg::mbes_rx_evt_s rx_evt,   // rx events
    output mbes_pkg::mbes_tx_evt_s tx_evt    // tx events
);
    initial begin
        rx_evt = '0;
        tx_evt = '0;
    end

    task automatic rx_frame(input logic [15:0] n, input logic bc,
                            input logic [4:0] er, input logic vl);
        @(posedge core_clk);
        rx_evt <= {1'b1, bc, er, vl, n};
        @(posedge core_clk);
        // stale qualifiers flipped so no old value lingers
        rx_evt <= {1'b0, ~bc, ~er, ~vl, ~n};
    endtask

    task automatic tx_frame(input logic [15:0] n, input logic bc,
                            input logic vl);
        @(posedge core_clk);
        tx_evt <= {1'b1, bc, vl, n, tx_evt[5:0]};
        @(posedge core_clk);
        tx_evt <= {1'b0, ~bc, ~vl, ~n, tx_evt[5:0]};
    endtask

    task automatic tx_abort();
        @(posedge core_clk);
        tx_evt.abort_excess <= 1'b1;
        @(posedge core_clk);
        tx_evt.abort_excess <= 1'b0;
    endtask

    // ****
    // carrier drops inside one transmitted frame
    // ****
    task automatic drop();
        @(posedge core_clk);
        tx_evt.start    <= 1'b0;
        tx_evt.sfd_sent <= 1'b0;
        tx_evt.carrier  <= 1'b0;
        @(posedge core_clk);
        tx_evt.carrier <= 1'b1;
    endtask

    task automatic crs_frame(input int early, input int late,
                             input logic col);
        @(posedge core_clk);
        tx_evt.start   <= 1'b1;
        tx_evt.carrier <= 1'b1;
        repeat (early) drop();
        @(posedge core_clk);
        tx_evt.start     <= 1'b0;
        tx_evt.sfd_sent  <= 1'b1;
        tx_evt.collision <= col;
        repeat (late) drop();
        @(posedge core_clk);
        tx_evt.sfd_sent  <= 1'b0;
        tx_evt.end_frame <= 1'b1;
        @(posedge core_clk);
        tx_evt.end_frame <= 1'b0;
        tx_evt.collision <= 1'b0;
        tx_evt.carrier   <= 1'b0;
    endtask
endmodule

/* tb/mbes_stats_asserts.sv */
// port assertions for the statistics counters
// assumes a bind onto mbes_stats; one clock, sync reset
`timescale 1ns/1ps

module mbes_stats_asserts #(
    parameter logic [31:0] OCTET_MAX = 32'h0fffffff,
    parameter logic [15:0] CARR_MAX  = 16'hffff,
    parameter logic [15:0] COLL_MAX  = 16'h0fff
) (
    input wire logic                   core_clk,                // clock
    input wire logic                   sys_rst,                 // reset
    input wire logic [7:0]             reg_addr,                // offset
    input wire logic                   reg_wr,                  // write
    input wire logic                   reg_rd,                  // read
    input wire logic [31:0]            reg_wdata,               // wdata
    input wire logic [31:0]            reg_rdata,               // rdata
    input wire logic                   reg_rvalid,              // valid
    input wire logic                   global_counting_on,      // enable
    input wire logic [3:0]             per_counter_inhibit,     // mask
    input wire mbes_pkg::mbes_rx_evt_s rx_evt,                  // rx
    input wire mbes_pkg::mbes_tx_evt_s tx_evt,                  // tx
    input wire logic                   counter_threshold_event  // event
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);

    // ****
    // steps of a load and read back
    // ****
    sequence wr_at(logic [7:0] a);
        reg_wr && reg_addr == a;
    endsequence
    sequence rd_at(logic [7:0] a);
        reg_rd && reg_addr == a;
    endsequence
    // nothing that could move a counter in between
    sequence quiet;
        !reg_wr && !rx_evt.done && !tx_evt.done_ok
            && !tx_evt.abort_excess && !$fell(tx_evt.carrier);
    endsequence

    reset_clear_a: assert property (disable iff (1'b0)
        sys_rst |=> reg_rdata == 32'h0 && !reg_rvalid
            && !counter_threshold_event) else $error("reset left outputs");
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read got no valid");
    valid_cause_a: assert property (
        reg_rvalid |-> $past(reg_rd)) else $error("valid without read");
    unmapped_zero_a: assert property (
        reg_rd && !(reg_addr inside {8'hb0, 8'hd8, 8'hf8, 8'hfc})
        |=> reg_rdata == 32'h0) else $error("unmapped read not zero");
    short_upper_a: assert property (
        rd_at(8'hf8) or rd_at(8'hfc) |=> reg_rdata[31:16] == 16'h0)
        else $error("short counter upper half set");
    octet_load_a: assert property (
        wr_at(8'hb0) ##1 quiet ##1 rd_at(8'hb0)
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("octet load lost");
    short_load_a: assert property (
        wr_at(8'hf8) ##1 quiet ##1 rd_at(8'hf8)
        |=> reg_rdata == ($past(reg_wdata, 3) & 32'h0000ffff))
        else $error("carrier load lost");
    event_gate_a: assert property (
        counter_threshold_event |-> $past(global_counting_on)
            && $past(per_counter_inhibit) != 4'hf)
        else $error("event while counting off");
    event_cause_a: assert property (
        counter_threshold_event |-> $past(rx_evt.done)
            || $past(tx_evt.done_ok) || $past(tx_evt.abort_excess)
            || !$past(tx_evt.carrier)) else $error("event without cause");
endmodule

/* tb/tb_mbes_stats.sv */
// self-checking bench for the statistics counters
// assumes mbes_mac_model drives every event input
`timescale 1ns/1ps

module tb_mbes_stats;
    // full 32-bit wrap so the octet threshold is reachable
    localparam logic [31:0] OCT_MAX = 32'hffffffff;
    localparam logic [7:0]  ADR [4] = '{8'hb0, 8'hd8, 8'hf8, 8'hfc};
    logic                   core_clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
    logic                   global_counting_on, counter_threshold_event;
    logic [7:0]             reg_addr;
    logic [31:0]            reg_wdata, reg_rdata;
    logic [3:0]             per_counter_inhibit;
    mbes_pkg::mbes_rx_evt_s rx_evt;
    mbes_pkg::mbes_tx_evt_s tx_evt;
    int                     failures, checks_done, events;

    mbes_stats #(.OCTET_MAX(OCT_MAX)) dut (.core_clk(core_clk),
        .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .global_counting_on(global_counting_on),
        .per_counter_inhibit(per_counter_inhibit), .rx_evt(rx_evt),
        .tx_evt(tx_evt), .counter_threshold_event(counter_threshold_event));
    mbes_mac_model mac (.core_clk(core_clk), .rx_evt(rx_evt),
        .tx_evt(tx_evt));

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (counter_threshold_event === 1'b1)
        events <= events + 1;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        for (int i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
            @(posedge core_clk);
        if (reg_rvalid !== 1'b1) begin
            failures++;
            complete_run();
        end
        check(reg_rdata, exp);
    endtask

    // ****
    // scenarios
    // ****
    task automatic t_rx_tx();
        mac.rx_frame(16'h40, 1'b1, 5'h0, 1'b0);
        mac.rx_frame(16'h3c, 1'b1, 5'h0, 1'b1);
        mac.rx_frame(16'h40, 1'b0, 5'h0, 1'b0);
        for (int j = 0; j < 5; j++)
            mac.rx_frame(16'h40, 1'b1, 5'h1 << j, 1'b0);
        rd_chk(ADR[0], 32'h80);
        mac.tx_frame(16'h64, 1'b1, 1'b0);
        mac.tx_frame(16'h60, 1'b1, 1'b1);
        mac.tx_frame(16'h32, 1'b0, 1'b0);
        rd_chk(ADR[1], 32'hc8);
    endtask
    task automatic t_carrier();
        mac.crs_frame(2, 0, 1'b0);
        rd_chk(ADR[2], 32'h0);
        mac.crs_frame(0, 2, 1'b0);
        mac.crs_frame(0, 1, 1'b1);
        rd_chk(ADR[2], 32'h2);
        mac.tx_abort();
        mac.tx_abort();
        rd_chk(ADR[3], 32'h2);
    endtask
    task automatic t_wrap();
        wr(ADR[0], OCT_MAX - 32'hf);
        mac.rx_frame(16'h20, 1'b1, 5'h0, 1'b0);
        rd_chk(ADR[0], 32'h10);
        wr(ADR[1], OCT_MAX - 32'hf);
        mac.tx_frame(16'h20, 1'b1, 1'b0);
        rd_chk(ADR[1], 32'h10);
        wr(ADR[2], 32'hffff);
        rd_chk(ADR[2], 32'hffff);
        mac.crs_frame(0, 1, 1'b0);
        rd_chk(ADR[2], 32'h0);
        wr(ADR[3], {16'h0, mbes_pkg::COLL_WRAP});
        mac.tx_abort();
        rd_chk(ADR[3], 32'h0);
    endtask
    task automatic t_thresh();
        int e0;
        e0 = events;
        // writes alone never raise the event
        wr(ADR[1], mbes_pkg::OCTET_THRESHOLD);
        wr(ADR[0], mbes_pkg::OCTET_THRESHOLD - 32'h10);
        mac.rx_frame(16'h10, 1'b1, 5'h0, 1'b0);
        wr(ADR[1], mbes_pkg::OCTET_THRESHOLD - 32'h4);
        mac.tx_frame(16'h4, 1'b1, 1'b0);
        repeat (3) @(posedge core_clk);
        check(32'(events - e0), 32'h2);
        wr(ADR[2], 32'hbfff);
        mac.crs_frame(0, 1, 1'b0);
        repeat (3) @(posedge core_clk);
        check(32'(events - e0), 32'h3);
    endtask
    task automatic t_race();
        fork
            wr(ADR[0], 32'h5);
            mac.rx_frame(16'h40, 1'b1, 5'h0, 1'b0);
        join
        rd_chk(ADR[0], 32'h5);
    endtask
    task automatic t_gate();
        logic [31:0] exp [4];
        for (int k = 0; k < 4; k++) begin
            wr(ADR[k], 32'h0);
            exp[k] = 32'h0;
        end
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            global_counting_on  <= (i != 4);
            per_counter_inhibit <= (i < 4) ? 4'h1 << i : 4'h0;
            mac.rx_frame(16'h8, 1'b1, 5'h0, 1'b0);
            mac.tx_frame(16'h8, 1'b1, 1'b0);
            mac.crs_frame(0, 1, 1'b0);
            mac.tx_abort();
            for (int k = 0; k < 4; k++) begin
                if (i == 5 || (i < 4 && i != k))
                    exp[k] += (k < 2) ? 32'h8 : 32'h1;
                rd_chk(ADR[k], exp[k]);
            end
        end
    endtask

    initial begin
        #2000000;
        failures++;
        complete_run();
    end
    initial begin
        sys_rst             = 1'b1;
        reg_wr              = 1'b0;
        reg_rd              = 1'b0;
        reg_addr            = 8'h0;
        reg_wdata           = 32'h0;
        global_counting_on  = 1'b1;
        per_counter_inhibit = 4'h0;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (int k = 0; k < 4; k++)
            rd_chk(ADR[k], 32'h0);
        rd_chk(8'h10, 32'h0);
        t_rx_tx();
        t_carrier();
        t_wrap();
        t_thresh();
        t_race();
        t_gate();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        @(posedge core_clk);
        sys_rst <= 1'b0;
        rd_chk(ADR[1], 32'h0);
        complete_run();
    end
endmodule

bind mbes_stats mbes_stats_asserts #(.OCTET_MAX(OCTET_MAX),
    .CARR_MAX(CARR_MAX), .COLL_MAX(COLL_MAX)) chk (.core_clk(core_clk),
    .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .global_counting_on(global_counting_on),
    .per_counter_inhibit(per_counter_inhibit), .rx_evt(rx_evt),
    .tx_evt(tx_evt), .counter_threshold_event(counter_threshold_event));
